// ===== rtl/itm_monitor.sv
// Purpose: interrupt task error monitor top level
// Assumes: task and refresh inputs come from logic on clk
// Notes: registers on a plain address/strobe port
`timescale 1ns/1ps
module itm_monitor
#(
   parameter int OVERRUN_LIMIT = itm_pkg::OVERRUN_CYCLES,
   parameter int UNITS = itm_pkg::UNIT_COUNT
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic int_task_active,
   input wire logic [7:0] int_task_num,
   input wire logic [4:0] cyc_task_num,
   input wire logic refresh_busy,
   input wire logic int_access,
   input wire logic [6:0] int_unit,
   input wire logic cyc_access,
   input wire logic [6:0] cyc_unit,
   input wire logic end_refresh,
   input wire logic [6:0] end_unit,
   input wire logic [UNITS-1:0] cyclic_enable,
   input wire logic program_error,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic interrupt_task_fault_flag,
   output logic special_unit_fault_flag,
   output logic unit_refresh_halt,
   output logic access_execute,
   output logic instruction_error,
   output logic irq
);
   import itm_pkg::*;

   logic [15:0] interrupt_error_capture_word;
   logic [15:0] stopped_task_number_word;
   logic [15:0] ctrl;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;
   logic stopped;
   logic trip;
   logic conflict;
   logic [6:0] conflict_unit;

   // ==========================================
   // Detectors
   itm_overrun_timer #(.LIMIT(OVERRUN_LIMIT)) u_timer
   (
      .clk(clk),
      .rst_b(rst_b),
      .task_active(int_task_active),
      .refresh_busy(refresh_busy),
      .trip(trip)
   );

   itm_conflict_check #(.UNITS(UNITS)) u_conflict
   (
      .clk(clk),
      .rst_b(rst_b),
      .int_access(int_access),
      .int_unit(int_unit),
      .cyc_access(cyc_access),
      .cyc_unit(cyc_unit),
      .end_refresh(end_refresh),
      .end_unit(end_unit),
      .cyclic_enable(cyclic_enable),
      .conflict(conflict),
      .execute(access_execute),
      .conflict_unit(conflict_unit)
   );

   // ==========================================
   // Decode and capture values
   wire detect_on = ctrl[CTRL_DETECT_BIT];
   wire wr_ctrl = wr && (addr == ADDR_CTRL);
   wire wr_ien = wr && (addr == ADDR_IRQ_ENABLE);
   wire wr_iclr = wr && (addr == ADDR_IRQ_CLEAR);
   wire resume = wr_ctrl && wdata[CTRL_RESUME_BIT];
   wire [15:0] overrun_code = {1'b0, 3'b000, 4'h0, int_task_num}; // see [RL4] [RL5]
   wire [15:0] conflict_code = {1'b1, 3'b000, 5'h00, conflict_unit}; // see [RL6] [RL5]
   wire [15:0] stop_code = int_task_active ? (STOP_INT_BASE | {8'h00, int_task_num})
                                           : (STOP_CYC_BASE | {11'h000, cyc_task_num}); // see [RL10]
   wire [1:0] events = {conflict, trip};
   wire [1:0] next_irq_status = (irq_status & ~(wr_iclr ? wdata[1:0] : 2'b00)) | events;
   wire [15:0] next_rdata =
      (addr == ADDR_CAPTURE) ? interrupt_error_capture_word :
      (addr == ADDR_STOP) ? stopped_task_number_word :
      (addr == ADDR_CTRL) ? ctrl :
      (addr == ADDR_FLAGS) ? {13'h0000, unit_refresh_halt, special_unit_fault_flag,
                              interrupt_task_fault_flag} :
      (addr == ADDR_IRQ_STATUS) ? {14'h0000, irq_status} :
      (addr == ADDR_IRQ_ENABLE) ? {14'h0000, irq_enable} : 16'h0000;

   // Control and interrupt registers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ctrl <= CTRL_RESET;
         irq_enable <= 2'b00;
         irq_status <= 2'b00;
         irq <= 1'b0;
         rdata <= 16'h0000;
      end
      else
      begin
         if (wr_ctrl) ctrl <= {15'h0000, wdata[CTRL_DETECT_BIT]};
         if (wr_ien) irq_enable <= wdata[1:0];
         irq_status <= next_irq_status; // Set wins over clear
         irq <= |(next_irq_status & irq_enable);
         rdata <= rd ? next_rdata : 16'h0000;
      end
   end

   // Fault flags and capture word
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         interrupt_task_fault_flag <= 1'b0;
         special_unit_fault_flag <= 1'b0;
         unit_refresh_halt <= 1'b0;
         interrupt_error_capture_word <= 16'h0000;
      end
      else
      begin
         if (trip)
         begin
            special_unit_fault_flag <= 1'b1; // see [RL3]
            unit_refresh_halt <= 1'b1; // see [RL3]
         end
         else if (resume)
         begin
            special_unit_fault_flag <= 1'b0;
            unit_refresh_halt <= 1'b0;
         end
         if (detect_on && (trip || conflict)) // see [RL1]
         begin
            interrupt_task_fault_flag <= 1'b1;
            interrupt_error_capture_word <= conflict ? conflict_code : overrun_code;
         end
         else if (resume)
            interrupt_task_fault_flag <= 1'b0;
      end
   end

   // Stop word: first program error holds
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         stopped <= 1'b0;
         stopped_task_number_word <= 16'h0000;
         instruction_error <= 1'b0;
      end
      else
      begin
         instruction_error <= 1'b0; // see [RL9]
         if (program_error && !stopped)
         begin
            stopped <= 1'b1;
            stopped_task_number_word <= stop_code; // see [RL10]
         end
      end
   end

   // ==========================================
   // Checks
   a_detect_gate: assert property (@(posedge clk) disable iff (!rst_b) // see [RL1]
      !detect_on |=> $stable(interrupt_error_capture_word))
      else $error("capture changed while detection off");
   a_overrun_halt: assert property (@(posedge clk) disable iff (!rst_b) // see [RL3]
      trip |=> unit_refresh_halt && special_unit_fault_flag)
      else $error("overrun did not halt refresh");
   a_overrun_code: assert property (@(posedge clk) disable iff (!rst_b) // see [RL4]
      (trip && !conflict && detect_on) |=> !interrupt_error_capture_word[KIND_BIT]
         && interrupt_error_capture_word[7:0] == $past(int_task_num))
      else $error("overrun code wrong");
   a_conflict_code: assert property (@(posedge clk) disable iff (!rst_b) // see [RL6]
      (conflict && detect_on) |=> interrupt_error_capture_word[KIND_BIT]
         && interrupt_error_capture_word[6:0] == $past(conflict_unit))
      else $error("conflict code wrong");
   a_flag_set: assert property (@(posedge clk) disable iff (!rst_b) // see [RL5]
      (detect_on && (trip || conflict)) |=> interrupt_task_fault_flag)
      else $error("fault flag not set");
   a_cyc_clash: assert property (@(posedge clk) disable iff (!rst_b) // see [RL7]
      (int_access && cyc_access && cyc_unit == int_unit) |=> conflict && !access_execute)
      else $error("cyclic clash missed");
   a_end_clash: assert property (@(posedge clk) disable iff (!rst_b) // see [RL8]
      (int_access && end_refresh && end_unit == int_unit) |=> conflict)
      else $error("end refresh clash missed");
   a_no_instr_err: assert property (@(posedge clk) disable iff (!rst_b) // see [RL9]
      conflict |-> !instruction_error)
      else $error("instruction error on conflict");
   a_stop_code: assert property (@(posedge clk) disable iff (!rst_b) // see [RL10]
      (program_error && !stopped && int_task_active) |=> stopped_task_number_word[15]
         && stopped_task_number_word[7:0] == $past(int_task_num))
      else $error("stop word wrong");
   c_overrun: cover property (@(posedge clk) trip && detect_on);
   c_conflict: cover property (@(posedge clk) conflict && detect_on);
   c_stop: cover property (@(posedge clk) program_error && !stopped);
endmodule

// ===== rtl/itm_pkg.sv
// Purpose: constants for the interrupt task error monitor
// Assumes: 20 MHz clock, plain register port
// Notes: offsets are word addresses on the register port
//
// How it works
// [RL1] Flag and capture update only when detection enabled
// [RL2] Interrupt task over 10 ms during refresh
// [RL3] Overrun sets unit fault, halts unit refresh
// [RL4] Overrun: kind bit clear, task number low
// [RL5] Bit 15 selects overrun or conflict kind
// [RL6] Conflict: kind bit set, unit number low
// [RL7] Interrupt access meets cyclic access, same unit
// [RL8] Interrupt access meets end or cyclic refresh
// [RL9] Conflicting instruction skipped, no instruction error
// [RL10] Stop word codes interrupt or cyclic task
// [RL11] Program keeps interrupt tasks under 10 ms
// [RL12] User disables cyclic refresh for such units
package itm_pkg;
   // ==========================================
   // Register map
   localparam logic [3:0] ADDR_CAPTURE = 4'h0;
   localparam logic [3:0] ADDR_STOP = 4'h1;
   localparam logic [3:0] ADDR_CTRL = 4'h2;
   localparam logic [3:0] ADDR_FLAGS = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
   localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h6;
   // ==========================================
   // Fields
   localparam int CTRL_DETECT_BIT = 0;
   localparam int CTRL_RESUME_BIT = 1;
   localparam int KIND_BIT = 15;
   localparam int NUM_W = 12;
   localparam logic [15:0] STOP_INT_BASE = 16'h8000;
   localparam logic [15:0] STOP_CYC_BASE = 16'h0000;
   localparam logic [1:0] IRQ_OVERRUN = 2'h1;
   localparam logic [1:0] IRQ_CONFLICT = 2'h2;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // ==========================================
   // Timing
   localparam int CLK_HZ = 20000000;
   localparam int OVERRUN_LIMIT_MS = 10;
   localparam int OVERRUN_CYCLES = CLK_HZ / 1000 * OVERRUN_LIMIT_MS;
   localparam int UNIT_COUNT = 96;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TRIPPED} overrun_state_t;
endpackage

// ===== rtl/itm_overrun_timer.sv
// Purpose: times one interrupt task against the overrun limit
// Assumes: task_active high for the whole task
// Notes: trip is a one-cycle pulse
`timescale 1ns/1ps
module itm_overrun_timer
#(
   parameter int LIMIT = 200000
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic task_active,
   input wire logic refresh_busy,
   output logic trip
);
   import itm_pkg::*;
   logic [31:0] count;
   overrun_state_t state;
   overrun_state_t next_state;
   wire over = refresh_busy && (count >= 32'(LIMIT - 1)); // see [RL2]

   // ==========================================
   // Next state
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE: if (task_active) next_state = ST_RUN;
         ST_RUN: if (!task_active) next_state = ST_IDLE; else if (over) next_state = ST_TRIPPED;
         ST_TRIPPED: if (!task_active) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Counter and trip pulse
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= ST_IDLE;
         count <= 32'h0;
         trip <= 1'b0;
      end
      else
      begin
         state <= next_state;
         count <= (state == ST_RUN && task_active) ? count + 32'h1 : 32'h0;
         trip <= (state == ST_RUN) && task_active && over; // see [RL2]
      end
   end
endmodule

// ===== rtl/itm_conflict_check.sv
// Purpose: detects conflicting unit access from an interrupt task
// Assumes: one access request per cycle
// Notes: conflict and execute are one-cycle pulses, all outputs registered
`timescale 1ns/1ps
module itm_conflict_check
#(
   parameter int UNITS = 96
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic int_access,
   input wire logic [6:0] int_unit,
   input wire logic cyc_access,
   input wire logic [6:0] cyc_unit,
   input wire logic end_refresh,
   input wire logic [6:0] end_unit,
   input wire logic [UNITS-1:0] cyclic_enable,
   output logic conflict,
   output logic execute,
   output logic [6:0] conflict_unit
);
   wire valid_unit = int_unit < 7'(UNITS);
   wire hit_cyc = cyc_access && (cyc_unit == int_unit); // see [RL7]
   wire hit_end = end_refresh && (end_unit == int_unit); // see [RL8]
   wire hit_en = valid_unit && cyclic_enable[int_unit]; // see [RL8]
   wire clash = int_access && (hit_cyc || hit_end || hit_en);

   // Skip on clash, otherwise let it run
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         conflict <= 1'b0;
         execute <= 1'b0;
         conflict_unit <= 7'h00;
      end
      else
      begin
         conflict <= clash;
         execute <= int_access && !clash; // see [RL9]
         conflict_unit <= int_unit;
      end
   end
endmodule

// ===== dv/unit_side_model.sv
// Purpose: far side model, unit refresh and cyclic task access
// Assumes: bench requests on clk, one cycle of latency
// Notes: idle unit lines toggle so no stale value survives
`timescale 1ns/1ps
module unit_side_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic want_busy,
   input wire logic want_cyc,
   input wire logic want_end,
   input wire logic [6:0] unit_sel,
   output logic refresh_busy,
   output logic cyc_access,
   output logic [6:0] cyc_unit,
   output logic end_refresh,
   output logic [6:0] end_unit
);
   // ========================================
   // Refresh levels and unit numbers follow requests
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         refresh_busy <= 1'b0;
         cyc_access <= 1'b0;
         end_refresh <= 1'b0;
         cyc_unit <= 7'h00;
         end_unit <= 7'h00;
      end
      else
      begin
         refresh_busy <= want_busy;
         cyc_access <= want_cyc;
         end_refresh <= want_end;
         cyc_unit <= want_cyc ? unit_sel : ~cyc_unit; // Released: inverse
         end_unit <= want_end ? unit_sel : ~end_unit;
      end
   end
endmodule

// ===== dv/interrupt_task_error_monitor_tb.sv
// Purpose: self-checking bench for the error monitor
// Assumes: overrun limit shortened to LIM cycles
// Notes: expected values kept in integers beside the design
`timescale 1ns/1ps
module interrupt_task_error_monitor_tb;
   import itm_pkg::*;
   localparam int LIM = 20;
   logic clk, rst_b, int_task_active, int_access, program_error, wr, rd;
   logic want_busy, want_cyc, want_end, refresh_busy, cyc_access, end_refresh;
   logic [7:0] int_task_num;
   logic [4:0] cyc_task_num;
   logic [6:0] int_unit, unit_sel, cyc_unit, end_unit;
   logic [UNIT_COUNT-1:0] cyclic_enable;
   logic [3:0] addr;
   logic [15:0] wdata, rdata;
   logic itf, suf, halt, exec, ierr, irq;
   logic [31:0] seed;
   int mismatches, checks_done, detect, exp_cap, m;
   // ========================================
   // Design and far side
   itm_monitor #(.OVERRUN_LIMIT(LIM), .UNITS(UNIT_COUNT)) uut (.clk(clk), .rst_b(rst_b),
      .int_task_active(int_task_active), .int_task_num(int_task_num),
      .cyc_task_num(cyc_task_num), .refresh_busy(refresh_busy), .int_access(int_access),
      .int_unit(int_unit), .cyc_access(cyc_access), .cyc_unit(cyc_unit),
      .end_refresh(end_refresh), .end_unit(end_unit), .cyclic_enable(cyclic_enable),
      .program_error(program_error), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .interrupt_task_fault_flag(itf), .special_unit_fault_flag(suf),
      .unit_refresh_halt(halt), .access_execute(exec), .instruction_error(ierr), .irq(irq));
   unit_side_model far (.clk(clk), .rst_b(rst_b), .want_busy(want_busy),
      .want_cyc(want_cyc), .want_end(want_end), .unit_sel(unit_sel),
      .refresh_busy(refresh_busy), .cyc_access(cyc_access), .cyc_unit(cyc_unit),
      .end_refresh(end_refresh), .end_unit(end_unit));
   // ========================================
   // Clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      mismatches++;
      close_out();
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   // Interrupt task unit access, watches the execute pulse
   task automatic access(input logic [6:0] u, input logic e);
      logic seen;
      seen = 1'b0;
      @(posedge clk);
      int_access <= 1'b1;
      int_unit <= u;
      @(posedge clk);
      int_access <= 1'b0;
      // Execute pulse stands in the cycle after the request edge
      #1 seen = exec;
      @(posedge clk);
      #1 seen = seen | exec;
      chk("access_execute", {15'h0, e}, {15'h0, seen});
      chk("instruction_error", 16'h0, {15'h0, ierr});
   endtask
   // Clash modes: 0 cyclic task, 1 end refresh, 2 cyclic refresh
   task automatic conflict(input logic [6:0] u, input int k);
      unit_sel <= u;
      want_cyc <= (k == 0);
      want_end <= (k == 1);
      cyclic_enable <= (k == 2) ? ({{(UNIT_COUNT-1){1'b0}}, 1'b1} << u) : '0;
      repeat (2) @(posedge clk);
      access(u, 1'b0);
      want_cyc <= 1'b0;
      want_end <= 1'b0;
      cyclic_enable <= '0;
      if (detect != 0)
         exp_cap = 32'h8000 | u;
      rreg(ADDR_CAPTURE, exp_cap[15:0]);
      chk("fault_flag", detect[15:0], {15'h0, itf});
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ========================================
   // Main sequence
   initial
   begin
      {rst_b, int_task_active, int_access, program_error, wr, rd} = '0;
      {want_busy, want_cyc, want_end, int_task_num, cyc_task_num} = '0;
      {int_unit, unit_sel, addr, wdata, cyclic_enable} = '0;
      mismatches = 0;
      checks_done = 0;
      detect = 0;
      exp_cap = 0;
      seed = 32'h5cc0;
      do_reset();
      rreg(ADDR_CAPTURE, 16'h0000);
      conflict(7'd3, 0);
      $display("test detect_off done");
      wreg(ADDR_CTRL, 16'h0001);
      detect = 1;
      wreg(ADDR_IRQ_ENABLE, 16'h0003);
      for (m = 0; m < 3; m++)
      begin
         seed = lfsr(seed);
         conflict(7'(seed % 96), m);
      end
      conflict(7'd95, 0);
      chk("irq", 16'h1, {15'h0, irq});
      wreg(ADDR_IRQ_CLEAR, 16'h0002);
      rreg(ADDR_IRQ_STATUS, 16'h0000);
      access(7'd10, 1'b1);
      wreg(ADDR_CTRL, 16'h0003);
      $display("test conflict done");
      // Task longer than the limit on purpose
      want_busy <= 1'b1;
      int_task_num <= 8'd200;
      int_task_active <= 1'b1;
      repeat (LIM + 5) @(posedge clk);
      int_task_active <= 1'b0;
      want_busy <= 1'b0;
      repeat (2) @(posedge clk);
      chk("special_unit_fault_flag", 16'h1, {15'h0, suf});
      chk("unit_refresh_halt", 16'h1, {15'h0, halt});
      rreg(ADDR_CAPTURE, 16'h00C8);
      rreg(ADDR_IRQ_STATUS, 16'h0001);
      $display("test overrun done");
      cyc_task_num <= 5'd31;
      program_error <= 1'b1;
      @(posedge clk);
      program_error <= 1'b0;
      rreg(ADDR_STOP, 16'h001F);
      do_reset();
      int_task_num <= 8'd255;
      int_task_active <= 1'b1;
      program_error <= 1'b1;
      @(posedge clk);
      program_error <= 1'b0;
      int_task_active <= 1'b0;
      rreg(ADDR_STOP, 16'h80FF);
      $display("test stop_word done");
      close_out();
   end
endmodule
